// *** hw/gpp_debounce.sv ***
// One-pin de-bounce filter with bypass
`timescale 1ns/100ps
module gpp_debounce
    import gpp_pkg::*;
#(
    parameter int CNT_W = FILTER_CNT_W,
    parameter bit RESET_LEVEL = 1'b0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic raw_level,
    input wire logic filter_enable,
    input wire logic [CNT_W-1:0] hold_cycles,
    output logic level
);
    logic stable_reg;
    logic stable_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    wire differs_w = raw_level != stable_reg;
    wire settle_w = differs_w && (cnt_reg >= hold_cycles - CNT_W'(1));

    // Tracks raw while bypassed, so enabling never glitches the output
    assign stable_next = (!filter_enable || settle_w) ? raw_level : stable_reg;
    assign cnt_next = (!filter_enable || !differs_w || settle_w) ? '0 : cnt_reg + CNT_W'(1);
    assign level = filter_enable ? stable_reg : raw_level;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stable_reg <= RESET_LEVEL;
            cnt_reg <= '0;
        end else begin
            stable_reg <= stable_next;
            cnt_reg <= cnt_next;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_filter_settle: assert property (($past(filter_enable) && filter_enable && $changed(stable_reg))
        |-> $past(cnt_reg) == $past(hold_cycles) - CNT_W'(1))
        else $error("filtered level changed before the hold time");
    a_filter_bypass: assert property (!filter_enable |-> level == raw_level)
        else $error("bypassed filter does not follow its input");
endmodule

// *** hw/gpp_pkg.sv ***
// Package: register map, field layout, reset values and timing of the general-purpose pin port
package gpp_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_PA_ENABLE = 8'h50;
    localparam logic [7:0] IDX_PA_VALUE = 8'h51;
    localparam logic [7:0] IDX_PA_LEVEL = 8'h52;
    localparam logic [7:0] IDX_PIN_FUNC = 8'h53;
    localparam logic [7:0] IDX_PB_ENABLE = 8'h54;
    localparam logic [7:0] IDX_PB_VALUE = 8'h55;
    localparam logic [7:0] IDX_PB_LEVEL = 8'h56;
    localparam logic [7:0] IDX_PC_RISE_EN = 8'h57;
    localparam logic [7:0] IDX_PC_FALL_EN = 8'h58;
    localparam logic [7:0] IDX_PC_FLAGS = 8'h59;
    localparam logic [7:0] IDX_PC_LEVEL = 8'h5a;
    localparam logic [7:0] IDX_PC_FILT_EN = 8'h5b;
    localparam logic [7:0] IDX_BD_OUT_CTRL = 8'h5c;
    localparam logic [7:0] IDX_BD_STATUS = 8'h5d;
    localparam logic [7:0] IDX_BD_TRIGGER = 8'h5e;
    localparam logic [7:0] IDX_BD_PIN_CTRL = 8'h5f;

    // Reset values
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_BD_OUT_CTRL = 8'hf0;
    localparam logic [3:0] RST_BD_LEVEL = 4'hf;

    // Field positions in the pin-function register
    localparam int PF_SCAN_TAKEOVER_BIT = 7;
    localparam int PF_C_SOURCE_BIT = 5;

    // De-bounce timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int FILTER_BASE_MS = 1;
    localparam int FILTER_BASE_CYCLES = FILTER_BASE_MS * (1000000000 / CLK_PERIOD_PS);
    localparam int FILTER_CNT_W = 24;

    // Layout of the bidirectional pin control register
    typedef struct packed {
        logic [1:0] filter_enable;
        logic [1:0] base_select;
        logic [3:0] open_drain_select;
    } gpp_bidir_ctrl_t;

    // Captured AHB address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic mapped;
        logic [7:0] idx;
    } gpp_access_t;

endpackage

// *** hw/gpp_port.sv ***
// General-purpose pin port: two output ports, an input port, a 4-bit two-way port, AHB-Lite registers
//
// Overview of operation
// - Port A enable bit turns on pin driver
// - Port A value drives enabled port A pins
// - Port A status reads pin levels, read-only
// - Port B enable bit turns on pin driver
// - Port B value drives enabled port B pins
// - Port B status reads pin levels always
// - Enabled port C rising edge sets flag
// - Enabled port C falling edge sets flag
// - Port C flags cleared by writing one
// - Port C status reads present pin levels
// - Port C filter enable routes through de-bounce
// - Two-way register: levels high, enables low
// - Two-way status high nibble shows pin levels
// - Trigger high nibble enables falling-edge flags
// - Trigger low nibble enables rising-edge flags; status write-one clears
// - Control bits 7/6 filter pin pairs
// - Base select picks 1, 2, 4, 8 ms
// - Open-drain select drives only low
// - Source select picks port C input group
// - Takeover hands port A 5:4 to scan
`timescale 1ns/100ps
module gpp_port
    import gpp_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int CNT_W = FILTER_CNT_W,
    parameter int FILTER_BASE_CYCLES_P = FILTER_BASE_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [7:0] port_a_pin_in,
    output logic [7:0] port_a_out_value,
    output logic [7:0] port_a_drive_enable,
    input wire logic scan_dir_ud,
    input wire logic scan_dir_rl,
    input wire logic [7:0] port_b_pin_in,
    output logic [7:0] port_b_out_value,
    output logic [7:0] port_b_drive_enable,
    input wire logic [7:0] port_c_pin_in,
    input wire logic [7:0] alt_video_input_group,
    input wire logic [3:0] bidir_pin_in,
    output logic [3:0] bidir_out_value,
    output logic [3:0] bidir_out_enable
);
    // Software-visible registers
    logic [7:0] pa_en_reg;
    logic [7:0] pa_val_reg;
    logic [7:0] pb_en_reg;
    logic [7:0] pb_val_reg;
    logic [7:0] pin_func_reg;
    logic [7:0] pc_rise_en_reg;
    logic [7:0] pc_fall_en_reg;
    logic [7:0] pc_flags_reg;
    logic [7:0] pc_filt_en_reg;
    logic [7:0] bd_out_ctrl_reg;
    logic [3:0] bd_flags_reg;
    logic [7:0] bd_trigger_reg;
    logic [7:0] bd_pin_ctrl_reg;

    // Bus state
    gpp_access_t acc_reg;
    gpp_access_t acc_next;
    logic hreadyout_reg;
    logic [31:0] hrdata_reg;
    logic [7:0] rdata_w;

    // Synchronisers and edge history
    logic [7:0] pa_sync1_reg;
    logic [7:0] pa_sync2_reg;
    logic [7:0] pb_sync1_reg;
    logic [7:0] pb_sync2_reg;
    logic [7:0] pc_sync1_reg;
    logic [7:0] pc_sync2_reg;
    logic [3:0] bd_sync1_reg;
    logic [3:0] bd_sync2_reg;
    logic [7:0] pc_prev_reg;
    logic [3:0] bd_prev_reg;
    logic [7:0] pc_filt_w;
    logic [3:0] bd_filt_w;

    // Registered pin drivers
    logic [7:0] pa_out_reg;
    logic [7:0] pa_oe_reg;
    logic [7:0] pb_out_reg;
    logic [7:0] pb_oe_reg;
    logic [3:0] bd_out_reg;
    logic [3:0] bd_oe_reg;

    // Address phase capture; only upper address bits of zero map
    wire take_w = hsel && htrans[1] && hready;
    wire mapped_w = (haddr[ADDR_W-1:10] == '0);
    assign acc_next = '{valid: take_w, write: hwrite, mapped: mapped_w, idx: haddr[9:2]};

    // Data-phase write strobes
    wire wr_w = acc_reg.valid && acc_reg.write && acc_reg.mapped;
    wire [7:0] wdat_w = hwdata[7:0];
    wire wr_pa_en_w = wr_w && (acc_reg.idx == IDX_PA_ENABLE);
    wire wr_pa_val_w = wr_w && (acc_reg.idx == IDX_PA_VALUE);
    wire wr_pin_func_w = wr_w && (acc_reg.idx == IDX_PIN_FUNC);
    wire wr_pb_en_w = wr_w && (acc_reg.idx == IDX_PB_ENABLE);
    wire wr_pb_val_w = wr_w && (acc_reg.idx == IDX_PB_VALUE);
    wire wr_pc_rise_w = wr_w && (acc_reg.idx == IDX_PC_RISE_EN);
    wire wr_pc_fall_w = wr_w && (acc_reg.idx == IDX_PC_FALL_EN);
    wire wr_pc_flags_w = wr_w && (acc_reg.idx == IDX_PC_FLAGS);
    wire wr_pc_filt_w = wr_w && (acc_reg.idx == IDX_PC_FILT_EN);
    wire wr_bd_out_w = wr_w && (acc_reg.idx == IDX_BD_OUT_CTRL);
    wire wr_bd_status_w = wr_w && (acc_reg.idx == IDX_BD_STATUS);
    wire wr_bd_trig_w = wr_w && (acc_reg.idx == IDX_BD_TRIGGER);
    wire wr_bd_ctrl_w = wr_w && (acc_reg.idx == IDX_BD_PIN_CTRL);

    // Read mux, sampled in the single wait cycle so a preceding write is visible
    always_comb begin
        if (!acc_reg.mapped) begin
            rdata_w = RST_ZERO;
        end else if (acc_reg.idx == IDX_PA_ENABLE) begin
            rdata_w = pa_en_reg;
        end else if (acc_reg.idx == IDX_PA_VALUE) begin
            rdata_w = pa_val_reg;
        end else if (acc_reg.idx == IDX_PA_LEVEL) begin
            rdata_w = pa_sync2_reg;
        end else if (acc_reg.idx == IDX_PIN_FUNC) begin
            rdata_w = pin_func_reg;
        end else if (acc_reg.idx == IDX_PB_ENABLE) begin
            rdata_w = pb_en_reg;
        end else if (acc_reg.idx == IDX_PB_VALUE) begin
            rdata_w = pb_val_reg;
        end else if (acc_reg.idx == IDX_PB_LEVEL) begin
            rdata_w = pb_sync2_reg;
        end else if (acc_reg.idx == IDX_PC_RISE_EN) begin
            rdata_w = pc_rise_en_reg;
        end else if (acc_reg.idx == IDX_PC_FALL_EN) begin
            rdata_w = pc_fall_en_reg;
        end else if (acc_reg.idx == IDX_PC_FLAGS) begin
            rdata_w = pc_flags_reg;
        end else if (acc_reg.idx == IDX_PC_LEVEL) begin
            rdata_w = pc_filt_w;
        end else if (acc_reg.idx == IDX_PC_FILT_EN) begin
            rdata_w = pc_filt_en_reg;
        end else if (acc_reg.idx == IDX_BD_OUT_CTRL) begin
            rdata_w = bd_out_ctrl_reg;
        end else if (acc_reg.idx == IDX_BD_STATUS) begin
            rdata_w = {bd_filt_w, bd_flags_reg};
        end else if (acc_reg.idx == IDX_BD_TRIGGER) begin
            rdata_w = bd_trigger_reg;
        end else if (acc_reg.idx == IDX_BD_PIN_CTRL) begin
            rdata_w = bd_pin_ctrl_reg;
        end else begin
            rdata_w = RST_ZERO;
        end
    end

    // One wait state on reads, none on writes
    wire rd_phase_w = acc_reg.valid && !acc_reg.write;
    wire hreadyout_next = !(take_w && !hwrite);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_reg <= '0;
            hreadyout_reg <= 1'b1;
            hrdata_reg <= '0;
        end else begin
            acc_reg <= acc_next;
            hreadyout_reg <= hreadyout_next;
            hrdata_reg <= rd_phase_w ? {24'h00_0000, rdata_w} : hrdata_reg;
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;

    // Control register updates
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pa_en_reg <= RST_ZERO;
            pa_val_reg <= RST_ZERO;
            pin_func_reg <= RST_ZERO;
            pb_en_reg <= RST_ZERO;
            pb_val_reg <= RST_ZERO;
            pc_rise_en_reg <= RST_ZERO;
            pc_fall_en_reg <= RST_ZERO;
            pc_filt_en_reg <= RST_ZERO;
            bd_out_ctrl_reg <= RST_BD_OUT_CTRL;
            bd_trigger_reg <= RST_ZERO;
            bd_pin_ctrl_reg <= RST_ZERO;
        end else begin
            pa_en_reg <= wr_pa_en_w ? wdat_w : pa_en_reg;
            pa_val_reg <= wr_pa_val_w ? wdat_w : pa_val_reg;
            pin_func_reg <= wr_pin_func_w ? wdat_w : pin_func_reg;
            pb_en_reg <= wr_pb_en_w ? wdat_w : pb_en_reg;
            pb_val_reg <= wr_pb_val_w ? wdat_w : pb_val_reg;
            pc_rise_en_reg <= wr_pc_rise_w ? wdat_w : pc_rise_en_reg;
            pc_fall_en_reg <= wr_pc_fall_w ? wdat_w : pc_fall_en_reg;
            pc_filt_en_reg <= wr_pc_filt_w ? wdat_w : pc_filt_en_reg;
            bd_out_ctrl_reg <= wr_bd_out_w ? wdat_w : bd_out_ctrl_reg;
            bd_trigger_reg <= wr_bd_trig_w ? wdat_w : bd_trigger_reg;
            bd_pin_ctrl_reg <= wr_bd_ctrl_w ? wdat_w : bd_pin_ctrl_reg;
        end
    end

    // Input synchronisers; port C source mux sits ahead of the first stage
    wire [7:0] pc_src_w = pin_func_reg[PF_C_SOURCE_BIT] ? alt_video_input_group : port_c_pin_in;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pa_sync1_reg <= RST_ZERO;
            pa_sync2_reg <= RST_ZERO;
            pb_sync1_reg <= RST_ZERO;
            pb_sync2_reg <= RST_ZERO;
            pc_sync1_reg <= RST_ZERO;
            pc_sync2_reg <= RST_ZERO;
            bd_sync1_reg <= RST_BD_LEVEL;
            bd_sync2_reg <= RST_BD_LEVEL;
        end else begin
            pa_sync1_reg <= port_a_pin_in;
            pa_sync2_reg <= pa_sync1_reg;
            pb_sync1_reg <= port_b_pin_in;
            pb_sync2_reg <= pb_sync1_reg;
            pc_sync1_reg <= pc_src_w;
            pc_sync2_reg <= pc_sync1_reg;
            bd_sync1_reg <= bidir_pin_in;
            bd_sync2_reg <= bd_sync1_reg;
        end
    end

    // De-bounce filters
    gpp_bidir_ctrl_t bd_ctrl_w;
    assign bd_ctrl_w = bd_pin_ctrl_reg;
    wire [3:0] bd_filt_en_w = {{2{bd_ctrl_w.filter_enable[1]}}, {2{bd_ctrl_w.filter_enable[0]}}};
    wire [CNT_W-1:0] base_cycles_w = CNT_W'(FILTER_BASE_CYCLES_P);
    wire [CNT_W-1:0] bd_hold_w = base_cycles_w << bd_ctrl_w.base_select;

    // Port C has no duration select, so it runs on the base duration
    for (genvar i = 0; i < 8; i++) begin : g_pc_filter
        gpp_debounce #(.CNT_W(CNT_W), .RESET_LEVEL(1'b0)) u_filter (
            .hclk(hclk),
            .hresetn(hresetn),
            .raw_level(pc_sync2_reg[i]),
            .filter_enable(pc_filt_en_reg[i]),
            .hold_cycles(base_cycles_w),
            .level(pc_filt_w[i])
        );
    end

    for (genvar i = 0; i < 4; i++) begin : g_bd_filter
        gpp_debounce #(.CNT_W(CNT_W), .RESET_LEVEL(1'b1)) u_filter (
            .hclk(hclk),
            .hresetn(hresetn),
            .raw_level(bd_sync2_reg[i]),
            .filter_enable(bd_filt_en_w[i]),
            .hold_cycles(bd_hold_w),
            .level(bd_filt_w[i])
        );
    end

    // Edge events and sticky flags; a new edge beats a same-cycle clear
    wire [7:0] pc_rise_w = pc_rise_en_reg & pc_filt_w & ~pc_prev_reg;
    wire [7:0] pc_fall_w = pc_fall_en_reg & ~pc_filt_w & pc_prev_reg;
    wire [7:0] pc_clr_w = wr_pc_flags_w ? wdat_w : RST_ZERO;
    wire [7:0] pc_flags_next = (pc_flags_reg & ~pc_clr_w) | pc_rise_w | pc_fall_w;
    wire [3:0] bd_rise_w = bd_trigger_reg[3:0] & bd_filt_w & ~bd_prev_reg;
    wire [3:0] bd_fall_w = bd_trigger_reg[7:4] & ~bd_filt_w & bd_prev_reg;
    wire [3:0] bd_clr_w = wr_bd_status_w ? wdat_w[3:0] : 4'h0;
    wire [3:0] bd_flags_next = (bd_flags_reg & ~bd_clr_w) | bd_rise_w | bd_fall_w;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_prev_reg <= RST_ZERO;
            bd_prev_reg <= RST_BD_LEVEL;
            pc_flags_reg <= RST_ZERO;
            bd_flags_reg <= 4'h0;
        end else begin
            pc_prev_reg <= pc_filt_w;
            bd_prev_reg <= bd_filt_w;
            pc_flags_reg <= pc_flags_next;
            bd_flags_reg <= bd_flags_next;
        end
    end

    // Pin drivers
    wire takeover_w = pin_func_reg[PF_SCAN_TAKEOVER_BIT];
    wire [7:0] pa_out_next = takeover_w ? {pa_val_reg[7:6], scan_dir_ud, scan_dir_rl, pa_val_reg[3:0]}
                                        : pa_val_reg;
    wire [7:0] pa_oe_next = takeover_w ? {pa_en_reg[7:6], 2'b11, pa_en_reg[3:0]} : pa_en_reg;
    wire [3:0] bd_val_w = bd_out_ctrl_reg[7:4];
    wire [3:0] bd_en_w = bd_out_ctrl_reg[3:0];
    wire [3:0] bd_od_w = bd_ctrl_w.open_drain_select;
    // Open-drain pins release instead of driving high
    wire [3:0] bd_out_next = bd_val_w & ~bd_od_w;
    wire [3:0] bd_oe_next = bd_en_w & ~(bd_od_w & bd_val_w);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pa_out_reg <= RST_ZERO;
            pa_oe_reg <= RST_ZERO;
            pb_out_reg <= RST_ZERO;
            pb_oe_reg <= RST_ZERO;
            bd_out_reg <= 4'h0;
            bd_oe_reg <= 4'h0;
        end else begin
            pa_out_reg <= pa_out_next;
            pa_oe_reg <= pa_oe_next;
            pb_out_reg <= pb_val_reg;
            pb_oe_reg <= pb_en_reg;
            bd_out_reg <= bd_out_next;
            bd_oe_reg <= bd_oe_next;
        end
    end

    assign port_a_out_value = pa_out_reg;
    assign port_a_drive_enable = pa_oe_reg;
    assign port_b_out_value = pb_out_reg;
    assign port_b_drive_enable = pb_oe_reg;
    assign bidir_out_value = bd_out_reg;
    assign bidir_out_enable = bd_oe_reg;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_read_taken;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence

    a_bus_read_wait: assert property (s_read_taken |=> s_one_wait)
        else $error("read did not take exactly one wait state");
    a_pa_drive_enable: assert property (!$past(takeover_w) |-> pa_oe_reg == $past(pa_en_reg))
        else $error("port A drive enable does not follow its register");
    a_pa_out_value: assert property (port_a_out_value[3:0] == $past(pa_val_reg[3:0]))
        else $error("port A low bits do not follow the value register");
    a_pa_level_sync: assert property (pa_sync2_reg == $past(port_a_pin_in, 2))
        else $error("port A level is not the pin two cycles back");
    a_pb_drive_pair: assert property (pb_oe_reg == $past(pb_en_reg) && pb_out_reg == $past(pb_val_reg))
        else $error("port B drivers do not follow their registers");
    a_pb_level_sync: assert property (pb_sync2_reg == $past(port_b_pin_in, 2))
        else $error("port B level is not the pin two cycles back");
    a_pc_rise_flag: assert property (|pc_rise_w |=> (pc_flags_reg & $past(pc_rise_w)) == $past(pc_rise_w))
        else $error("port C rising edge did not set its flag");
    a_pc_fall_flag: assert property (|pc_fall_w |=> (pc_flags_reg & $past(pc_fall_w)) == $past(pc_fall_w))
        else $error("port C falling edge did not set its flag");
    a_pc_flag_clear: assert property ((wr_pc_flags_w && !(|(pc_rise_w | pc_fall_w)))
        |=> pc_flags_reg == ($past(pc_flags_reg) & ~$past(wdat_w)))
        else $error("port C write-one clear misbehaved");
    a_pc_source_select: assert property ($past(pin_func_reg[PF_C_SOURCE_BIT], 2)
        |-> pc_sync2_reg == $past(alt_video_input_group, 2))
        else $error("port C did not take the alternative input group");
    a_bd_open_drain: assert property (|(bd_od_w & bd_en_w) |=> (bd_out_reg & $past(bd_od_w)) == 4'h0)
        else $error("open-drain two-way pin driven high");
    a_bd_input_mode: assert property ($past(bd_en_w) == 4'h0 |-> bidir_out_enable == 4'h0)
        else $error("two-way pin driven while set as input");
    a_bd_fall_flag: assert property (|bd_fall_w |=> (bd_flags_reg & $past(bd_fall_w)) == $past(bd_fall_w))
        else $error("two-way falling edge did not set its flag");
    a_bd_pair_bypass: assert property (!bd_ctrl_w.filter_enable[1] |-> bd_filt_w[3:2] == bd_sync2_reg[3:2])
        else $error("two-way pins 3 and 2 filtered while disabled");
    a_scan_takeover: assert property ($past(takeover_w)
        |-> port_a_out_value[5:4] == $past({scan_dir_ud, scan_dir_rl}))
        else $error("scan direction did not reach port A bits 5 and 4");
endmodule

// *** verification/gpp_board_model.sv ***
// Board model: pin wires seen by the port, with external drivers and pull-ups
`timescale 1ns/100ps
module gpp_board_model (
    input wire logic [7:0] a_value,
    input wire logic [7:0] a_enable,
    input wire logic [7:0] a_ext,
    input wire logic [7:0] b_value,
    input wire logic [7:0] b_enable,
    input wire logic [7:0] b_ext,
    input wire logic [3:0] d_value,
    input wire logic [3:0] d_enable,
    input wire logic [3:0] d_pull_low,
    output logic [7:0] a_pin,
    output logic [7:0] b_pin,
    output logic [3:0] d_pin
);
    // Undriven output-port pins follow the board's own driver
    assign a_pin = (a_enable & a_value) | (~a_enable & a_ext);
    assign b_pin = (b_enable & b_value) | (~b_enable & b_ext);
    // Two-way lines carry pull-ups, so a released line reads high
    assign d_pin = (d_enable & d_value) | (~d_enable & ~d_pull_low);
endmodule

// *** verification/tb_top.sv ***
// Testbench: register-level checks of the general-purpose pin port
`timescale 1ns/100ps
module tb_top
    import gpp_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [7:0] a_in, a_val, a_en, b_in, b_val, b_en, v, base;
    logic [7:0] a_ext = 8'h00;
    logic [7:0] c_pin = 8'h00;
    logic [7:0] alt_in = 8'h00;
    logic [3:0] d_in, d_val, d_en;
    logic [3:0] d_low = 4'h0;
    logic rl = 1'b0;
    int n_mismatch = 0;
    int total_checks = 0;

    always #2.5 hclk = ~hclk;

    gpp_port #(.FILTER_BASE_CYCLES_P(4)) gpp_port_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .port_a_pin_in(a_in),
        .port_a_out_value(a_val), .port_a_drive_enable(a_en), .scan_dir_ud(1'b0), .scan_dir_rl(rl),
        .port_b_pin_in(b_in), .port_b_out_value(b_val), .port_b_drive_enable(b_en),
        .port_c_pin_in(c_pin), .alt_video_input_group(alt_in), .bidir_pin_in(d_in),
        .bidir_out_value(d_val), .bidir_out_enable(d_en));

    gpp_board_model gpp_board_model_inst (.a_value(a_val), .a_enable(a_en), .a_ext(a_ext),
        .b_value(b_val), .b_enable(b_en), .b_ext(a_ext), .d_value(d_val), .d_enable(d_en),
        .d_pull_low(d_low), .a_pin(a_in), .b_pin(b_in), .d_pin(d_in));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Bounded wait for the slave's ready at a rising edge
    task automatic wait_rdy();
        int n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            stop_test();
        end
    endtask

    task automatic bus(input logic [7:0] idx, input logic wr_en, input logic [7:0] wd);
        haddr <= {2'b00, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr_en;
        hsel <= 1'b1;
        wait_rdy();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= {24'h00_0000, wd};
        wait_rdy();
        v = hrdata[7:0];
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        bus(idx, 1'b0, 8'h00);
        chk(v, e);
        // Upper data bits stay zero and the response is always OKAY
        chk(hrdata[31:24] | hrdata[23:16] | hrdata[15:8] | {7'h00, hresp}, 8'h00);
    endtask

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // 0x60 is past the map and must read zero
        for (int i = 8'h50; i <= 8'h60; i++) begin
            rd(8'(i), (i == 8'h5c || i == 8'h5d) ? RST_BD_OUT_CTRL : RST_ZERO);
        end
        $display("reset values done");
        a_ext <= 8'h3c;
        for (int p = 0; p < 2; p++) begin
            base = p ? IDX_PB_ENABLE : IDX_PA_ENABLE;
            // Different patterns per port so a swapped register or pin path shows
            wr(base, p ? 8'hf0 : 8'h0f);
            wr(base + 8'h01, p ? 8'h5a : 8'ha5);
            repeat (4) @(posedge hclk);
            chk(p ? b_en : a_en, p ? 8'hf0 : 8'h0f);
            chk(p ? b_val : a_val, p ? 8'h5a : 8'ha5);
            wr(base + 8'h02, 8'hff);
            rd(base + 8'h02, p ? 8'h5c : 8'h35);
        end
        rl <= 1'b1;
        wr(IDX_PIN_FUNC, 8'h80);
        repeat (2) @(posedge hclk);
        chk(a_val, 8'h95);
        chk(a_en, 8'h3f);
        wr(IDX_PIN_FUNC, 8'h00);
        repeat (2) @(posedge hclk);
        chk(a_val, 8'ha5);
        $display("output ports done");
        wr(IDX_PC_RISE_EN, 8'h0f);
        wr(IDX_PC_FALL_EN, 8'h3c);
        c_pin <= 8'hff;
        repeat (4) @(posedge hclk);
        rd(IDX_PC_LEVEL, 8'hff);
        rd(IDX_PC_FLAGS, 8'h0f);
        c_pin <= 8'h00;
        repeat (4) @(posedge hclk);
        rd(IDX_PC_FLAGS, 8'h3f);
        wr(IDX_PC_FLAGS, 8'h05);
        wr(IDX_PC_FLAGS, 8'h00);
        rd(IDX_PC_FLAGS, 8'h3a);
        alt_in <= 8'h81;
        wr(IDX_PIN_FUNC, 8'h20);
        repeat (4) @(posedge hclk);
        rd(IDX_PC_LEVEL, 8'h81);
        rd(IDX_PC_FLAGS, 8'h3b);
        wr(IDX_PIN_FUNC, 8'h00);
        wr(IDX_PC_FLAGS, 8'hff);
        rd(IDX_PC_FLAGS, 8'h00);
        // A two-cycle glitch is shorter than the four-cycle base hold
        wr(IDX_PC_FILT_EN, 8'h01);
        c_pin <= 8'h01;
        repeat (2) @(posedge hclk);
        c_pin <= 8'h00;
        repeat (8) @(posedge hclk);
        rd(IDX_PC_FLAGS, 8'h00);
        c_pin <= 8'h01;
        repeat (10) @(posedge hclk);
        rd(IDX_PC_FLAGS, 8'h01);
        $display("input port done");
        wr(IDX_BD_OUT_CTRL, 8'ha3);
        repeat (4) @(posedge hclk);
        chk({4'h0, d_en}, 8'h03);
        chk({4'h0, d_val}, 8'h0a);
        rd(IDX_BD_STATUS, 8'he0);
        wr(IDX_BD_PIN_CTRL, 8'h03);
        repeat (2) @(posedge hclk);
        chk({4'h0, d_en}, 8'h01);
        chk({7'h00, d_val[0]}, 8'h00);
        rd(IDX_BD_STATUS, 8'he0);
        wr(IDX_BD_TRIGGER, 8'h84);
        d_low <= 4'hc;
        repeat (4) @(posedge hclk);
        rd(IDX_BD_STATUS, 8'h28);
        d_low <= 4'h0;
        repeat (4) @(posedge hclk);
        rd(IDX_BD_STATUS, 8'hec);
        wr(IDX_BD_STATUS, 8'h04);
        rd(IDX_BD_STATUS, 8'he8);
        // Base select 01 doubles the hold to eight cycles; six must not pass
        wr(IDX_BD_PIN_CTRL, 8'h53);
        // Pin 1 falling edge armed, so a glitch that slips through leaves a flag
        wr(IDX_BD_TRIGGER, 8'ha4);
        d_low <= 4'h2;
        repeat (6) @(posedge hclk);
        d_low <= 4'h0;
        repeat (4) @(posedge hclk);
        rd(IDX_BD_STATUS, 8'he8);
        d_low <= 4'h2;
        repeat (12) @(posedge hclk);
        rd(IDX_BD_STATUS, 8'hca);
        $display("two-way port done");
        stop_test();
    end
endmodule
